/* inc/qpdp_pkg.sv */
package qpdp_pkg;

   // ----------------------------------------
   // Bus geometry
   // ----------------------------------------
   localparam int DW = 64;
   localparam int GW = 16;
   localparam int NG = 4;
   localparam int NW = 4;
   localparam int LW = NW * DW;

   // ----------------------------------------
   // Timing: sys cycles per word, per chunk
   // ----------------------------------------
   localparam int PH_PER_WORD = 2;
   localparam int CHUNK_PH = NW * PH_PER_WORD;
   localparam logic [2:0] PH_LAST = 3'(CHUNK_PH - 1);

   // ----------------------------------------
   // Idle and reset values of the lines, half-group threshold
   // ----------------------------------------
   localparam logic [DW-1:0] IDLE_DATA = 64'hffff_ffff_ffff_ffff;
   localparam logic [NG-1:0] IDLE_GRP = 4'hf;
   localparam logic [4:0] HALF_GRP = 5'h08;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_SEND = 3'h2,
      ST_GAP  = 3'h4
   } qpdp_state_t;

   // ----------------------------------------
   // Group coding helpers
   // ----------------------------------------
   // Returns {flag line, group lines}; flag line low means inverted
   function automatic logic [GW:0] qpdp_dbi_enc(input logic [GW-1:0] d, input logic [GW-1:0] prev);
      logic [GW-1:0] w;
      logic [4:0] n;
      w = ~d;
      n = 5'h00;
      for (int i = 0; i < GW; i++) begin
         n = n + 5'(w[i] ^ prev[i]);
      end
      if (n > HALF_GRP) begin
         return {1'b0, d};
      end
      return {1'b1, w};
   endfunction

   function automatic logic [GW-1:0] qpdp_dbi_dec(input logic [GW-1:0] w, input logic flag_n);
      return flag_n ? ~w : w;
   endfunction

   // Even parity over the lines as driven
   function automatic logic qpdp_par(input logic [GW-1:0] w);
      return ^w;
   endfunction

endpackage

/* inc/qpdp_bus_if.sv */
`timescale 1ns/1ps
interface qpdp_bus_if;

   // ----------------------------------------
   // Shared lines; all but bus_clk active low, pulled high
   // ----------------------------------------
   logic bus_clk;
   logic [63:0] data;
   logic [3:0] positive_data_strobes;
   logic [3:0] negative_data_strobes;
   logic [3:0] group_inversion_flags;
   logic [3:0] data_parity_lines;
   logic data_valid_indicator;
   logic data_bus_in_use;
   logic out_of_order_a;

   // ----------------------------------------
   // Per-party drivers
   // ----------------------------------------
   logic [63:0] cpu_data_o, chip_data_o;
   logic [3:0] cpu_pstb_o, chip_pstb_o, cpu_nstb_o, chip_nstb_o;
   logic [3:0] cpu_flag_o, chip_flag_o, cpu_par_o, chip_par_o;
   logic cpu_data_valid_indicator_o, chip_data_valid_indicator_o, cpu_drv_oe_n, chip_drv_oe_n;
   logic cpu_busy_o, chip_busy_o, cpu_busy_oe_n, chip_busy_oe_n;
   logic chip_out_of_order_a_o, chip_out_of_order_a_oe_n;

   // ----------------------------------------
   // Wired resolution
   // ----------------------------------------
   assign data = (cpu_drv_oe_n ? '1 : cpu_data_o) & (chip_drv_oe_n ? '1 : chip_data_o);
   assign positive_data_strobes = (cpu_drv_oe_n ? '1 : cpu_pstb_o) & (chip_drv_oe_n ? '1 : chip_pstb_o);
   assign negative_data_strobes = (cpu_drv_oe_n ? '1 : cpu_nstb_o) & (chip_drv_oe_n ? '1 : chip_nstb_o);
   assign group_inversion_flags = (cpu_drv_oe_n ? '1 : cpu_flag_o) & (chip_drv_oe_n ? '1 : chip_flag_o);
   assign data_parity_lines = (cpu_drv_oe_n ? '1 : cpu_par_o) & (chip_drv_oe_n ? '1 : chip_par_o);
   assign data_valid_indicator = (cpu_drv_oe_n | cpu_data_valid_indicator_o) & (chip_drv_oe_n | chip_data_valid_indicator_o);
   assign data_bus_in_use = (cpu_busy_oe_n | cpu_busy_o) & (chip_busy_oe_n | chip_busy_o);
   assign out_of_order_a = chip_out_of_order_a_oe_n | chip_out_of_order_a_o;

   modport cpu (
      input bus_clk, data, positive_data_strobes, negative_data_strobes, group_inversion_flags,
      input data_parity_lines, data_valid_indicator, data_bus_in_use, out_of_order_a,
      output cpu_data_o, cpu_pstb_o, cpu_nstb_o, cpu_flag_o, cpu_par_o, cpu_data_valid_indicator_o, cpu_drv_oe_n,
      output cpu_busy_o, cpu_busy_oe_n
   );

   modport chip (
      input bus_clk, data, positive_data_strobes, negative_data_strobes, group_inversion_flags,
      input data_parity_lines, data_valid_indicator, data_bus_in_use,
      output chip_data_o, chip_pstb_o, chip_nstb_o, chip_flag_o, chip_par_o, chip_data_valid_indicator_o, chip_drv_oe_n,
      output chip_busy_o, chip_busy_oe_n, chip_out_of_order_a_o, chip_out_of_order_a_oe_n
   );

endinterface

/* verilog/qpdp_chip_end.sv */
`timescale 1ns/1ps
module qpdp_chip_end (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic tx_valid,
   input wire logic [qpdp_pkg::LW-1:0] tx_line,
   input wire logic tx_last,
   input wire logic out_of_order_a_req,
   output logic tx_ready,
   output logic rx_valid,
   output logic [qpdp_pkg::LW-1:0] rx_line,
   output logic rx_par_err,
   qpdp_bus_if.chip bus
);

   logic [2:0] bclk_q;
   logic [63:0] d_s1_q, d_s2_q;
   logic [3:0] flg_s1_q, flg_s2_q, par_s1_q, par_s2_q;
   logic [3:0] ps_s1_q, ps_s2_q, ps_s3_q, ns_s1_q, ns_s2_q, ns_s3_q;
   logic [1:0] data_valid_indicator_s_q, busy_s_q;
   logic bclk_rise;
   qpdp_pkg::qpdp_state_t state_q;
   logic [2:0] ph_q;
   logic [qpdp_pkg::LW-1:0] line_q;
   logic last_q, tx_ready_q;
   logic [63:0] prev_q, enc_d, word;
   logic [3:0] enc_f, enc_p;
   logic [2:0] own_q;
   logic [1:0] widx_q [4];
   logic [3:0] done_q;
   logic [qpdp_pkg::LW-1:0] rx_line_q;
   logic rx_valid_q, par_err_q;

   assign tx_ready = tx_ready_q;
   assign rx_valid = rx_valid_q;
   assign rx_line = rx_line_q;
   assign rx_par_err = par_err_q;
   assign bclk_rise = bclk_q[1] & ~bclk_q[2];

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         // Ones: no false rise if the bus clock is high at release
         bclk_q <= 3'h7;
         {d_s1_q, d_s2_q} <= {2{qpdp_pkg::IDLE_DATA}};
         {flg_s1_q, flg_s2_q, par_s1_q, par_s2_q} <= {4{qpdp_pkg::IDLE_GRP}};
         {ps_s1_q, ps_s2_q, ps_s3_q} <= {3{qpdp_pkg::IDLE_GRP}};
         {ns_s1_q, ns_s2_q, ns_s3_q} <= {3{qpdp_pkg::IDLE_GRP}};
         data_valid_indicator_s_q <= 2'h3;
         busy_s_q <= 2'h3;
      end else begin
         bclk_q <= {bclk_q[1:0], bus.bus_clk};
         d_s1_q <= bus.data;
         d_s2_q <= d_s1_q;
         flg_s1_q <= bus.group_inversion_flags;
         flg_s2_q <= flg_s1_q;
         par_s1_q <= bus.data_parity_lines;
         par_s2_q <= par_s1_q;
         {ps_s3_q, ps_s2_q, ps_s1_q} <= {ps_s2_q, ps_s1_q, bus.positive_data_strobes};
         {ns_s3_q, ns_s2_q, ns_s1_q} <= {ns_s2_q, ns_s1_q, bus.negative_data_strobes};
         data_valid_indicator_s_q <= {data_valid_indicator_s_q[0], bus.data_valid_indicator};
         busy_s_q <= {busy_s_q[0], bus.data_bus_in_use};
      end
   end

   // ----------------------------------------
   // Out_of_order_a indication to the processor
   // ----------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         bus.chip_out_of_order_a_o <= 1'b0;
         bus.chip_out_of_order_a_oe_n <= 1'b1;
      end else begin
         bus.chip_out_of_order_a_oe_n <= ~out_of_order_a_req;
      end
   end

   // ----------------------------------------
   // Word encoder
   // ----------------------------------------
   always_comb begin
      word = line_q[{ph_q[2:1], 6'h00} +: 64];
      for (int g = 0; g < qpdp_pkg::NG; g++) begin
         {enc_f[g], enc_d[g*16 +: 16]} = qpdp_pkg::qpdp_dbi_enc(word[g*16 +: 16], prev_q[g*16 +: 16]);
         enc_p[g] = qpdp_pkg::qpdp_par(enc_d[g*16 +: 16]);
      end
   end

   // ----------------------------------------
   // Transmit sequencer
   // ----------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state_q <= qpdp_pkg::ST_IDLE;
         ph_q <= 3'h0;
         line_q <= '0;
         last_q <= 1'b0;
         tx_ready_q <= 1'b0;
         prev_q <= qpdp_pkg::IDLE_DATA;
         bus.chip_data_o <= qpdp_pkg::IDLE_DATA;
         bus.chip_flag_o <= qpdp_pkg::IDLE_GRP;
         bus.chip_par_o <= qpdp_pkg::IDLE_GRP;
         bus.chip_pstb_o <= qpdp_pkg::IDLE_GRP;
         bus.chip_nstb_o <= qpdp_pkg::IDLE_GRP;
         bus.chip_data_valid_indicator_o <= 1'b1;
         bus.chip_drv_oe_n <= 1'b1;
         bus.chip_busy_o <= 1'b0;
         bus.chip_busy_oe_n <= 1'b1;
      end else begin
         tx_ready_q <= 1'b0;
         case (state_q)
            qpdp_pkg::ST_IDLE: begin
               if (bclk_rise && tx_valid && busy_s_q[1]) begin
                  line_q <= tx_line;
                  last_q <= tx_last;
                  tx_ready_q <= 1'b1;
                  ph_q <= 3'h0;
                  bus.chip_drv_oe_n <= 1'b0;
                  bus.chip_busy_oe_n <= 1'b0;
                  state_q <= qpdp_pkg::ST_SEND;
               end
            end
            qpdp_pkg::ST_SEND: begin
               ph_q <= ph_q + 3'h1;
               if (!ph_q[0]) begin
                  bus.chip_data_o <= enc_d;
                  bus.chip_flag_o <= enc_f;
                  bus.chip_par_o <= enc_p;
                  prev_q <= enc_d;
                  bus.chip_pstb_o <= qpdp_pkg::IDLE_GRP;
                  bus.chip_nstb_o <= qpdp_pkg::IDLE_GRP;
                  bus.chip_data_valid_indicator_o <= 1'b0;
               end else if (!ph_q[1]) begin
                  bus.chip_pstb_o <= 4'h0;
               end else begin
                  bus.chip_nstb_o <= 4'h0;
               end
               if (ph_q == qpdp_pkg::PH_LAST) begin
                  state_q <= qpdp_pkg::ST_GAP;
               end
            end
            qpdp_pkg::ST_GAP: begin
               bus.chip_data_valid_indicator_o <= 1'b1;
               bus.chip_pstb_o <= qpdp_pkg::IDLE_GRP;
               bus.chip_nstb_o <= qpdp_pkg::IDLE_GRP;
               if (last_q) begin
                  bus.chip_drv_oe_n <= 1'b1;
                  bus.chip_busy_oe_n <= 1'b1;
                  bus.chip_data_o <= qpdp_pkg::IDLE_DATA;
                  bus.chip_flag_o <= qpdp_pkg::IDLE_GRP;
                  prev_q <= qpdp_pkg::IDLE_DATA;
                  state_q <= qpdp_pkg::ST_IDLE;
               end else if (bclk_rise && tx_valid) begin
                  line_q <= tx_line;
                  last_q <= tx_last;
                  tx_ready_q <= 1'b1;
                  ph_q <= 3'h0;
                  state_q <= qpdp_pkg::ST_SEND;
               end
            end
            default: state_q <= qpdp_pkg::ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // Receiver
   // ----------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         own_q <= 3'h0;
      end else begin
         own_q <= {own_q[1:0], ~bus.chip_drv_oe_n};
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         widx_q <= '{default: 2'h0};
         done_q <= 4'h0;
         rx_line_q <= '0;
         rx_valid_q <= 1'b0;
         par_err_q <= 1'b0;
      end else begin
         rx_valid_q <= &done_q;
         par_err_q <= 1'b0;
         if (busy_s_q[1] || (&done_q)) begin
            done_q <= 4'h0;
         end
         for (int g = 0; g < qpdp_pkg::NG; g++) begin
            if (busy_s_q[1]) begin
               widx_q[g] <= 2'h0;
            end
            if (((ps_s3_q[g] & ~ps_s2_q[g]) | (ns_s3_q[g] & ~ns_s2_q[g])) && !data_valid_indicator_s_q[1]
                && !(|own_q) && bus.chip_drv_oe_n) begin
               rx_line_q[{widx_q[g], 2'(g), 4'h0} +: 16] <=
                  qpdp_pkg::qpdp_dbi_dec(d_s2_q[g*16 +: 16], flg_s2_q[g]);
               if (qpdp_pkg::qpdp_par(d_s2_q[g*16 +: 16]) != par_s2_q[g]) begin
                  par_err_q <= 1'b1;
               end
               widx_q[g] <= widx_q[g] + 2'h1;
               if (widx_q[g] == 2'h3) begin
                  done_q[g] <= 1'b1;
               end
            end
         end
      end
   end

endmodule

/* verilog/qpdp_cpu_end.sv */
`timescale 1ns/1ps
// Behaviour
// - All agents share one 64-line active-low path
// - Driver sends four words per bus clock
// - Capture on falling edge of both strobes
// - Four 16-bit groups, each with own strobes
// - Invert group when over half bits change
// - Active flag means group sampled active high
// - Flags travel with their group's strobes
// - Driver asserts data-ready on each transfer
// - Driver holds bus-busy; others wait for release
// - Addressed agent asserts out_of_order_a for deferral
// - Driver also drives four parity lines
// - Data-ready gaps insert idle clocks; ignored
module qpdp_cpu_end (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic tx_valid,
   input wire logic [qpdp_pkg::LW-1:0] tx_line,
   input wire logic tx_last,
   output logic tx_ready,
   output logic rx_valid,
   output logic [qpdp_pkg::LW-1:0] rx_line,
   output logic rx_par_err,
   output logic deferred,
   qpdp_bus_if.cpu bus
);

   logic [2:0] bclk_q;
   logic [63:0] d_s1_q, d_s2_q;
   logic [3:0] flg_s1_q, flg_s2_q;
   logic [3:0] par_s1_q, par_s2_q;
   logic [3:0] ps_s1_q, ps_s2_q, ps_s3_q;
   logic [3:0] ns_s1_q, ns_s2_q, ns_s3_q;
   logic [1:0] data_valid_indicator_s_q;
   logic [1:0] busy_s_q;
   logic [1:0] out_of_order_a_s_q;
   logic bclk_rise;

   qpdp_pkg::qpdp_state_t state_q;
   logic [2:0] ph_q;
   logic [qpdp_pkg::LW-1:0] line_q;
   logic last_q;
   logic tx_ready_q;
   logic [63:0] prev_q;
   logic [63:0] enc_d;
   logic [63:0] word;
   logic [3:0] enc_f;
   logic [3:0] enc_p;

   logic [2:0] own_q;
   logic [1:0] widx_q [4];
   logic [3:0] done_q;
   logic [qpdp_pkg::LW-1:0] rx_line_q;
   logic rx_valid_q;
   logic par_err_q;
   logic deferred_q;

   assign tx_ready = tx_ready_q;
   assign rx_valid = rx_valid_q;
   assign rx_line = rx_line_q;
   assign rx_par_err = par_err_q;
   assign deferred = deferred_q;

   // Bus clock edge seen through its synchroniser
   assign bclk_rise = bclk_q[1] & ~bclk_q[2];

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         bclk_q <= 3'h7;
         d_s1_q <= qpdp_pkg::IDLE_DATA;
         d_s2_q <= qpdp_pkg::IDLE_DATA;
         flg_s1_q <= qpdp_pkg::IDLE_GRP;
         flg_s2_q <= qpdp_pkg::IDLE_GRP;
         par_s1_q <= qpdp_pkg::IDLE_GRP;
         par_s2_q <= qpdp_pkg::IDLE_GRP;
         {ps_s1_q, ps_s2_q, ps_s3_q} <= {3{qpdp_pkg::IDLE_GRP}};
         {ns_s1_q, ns_s2_q, ns_s3_q} <= {3{qpdp_pkg::IDLE_GRP}};
         data_valid_indicator_s_q <= 2'h3;
         busy_s_q <= 2'h3;
         out_of_order_a_s_q <= 2'h3;
      end else begin
         bclk_q <= {bclk_q[1:0], bus.bus_clk};
         d_s1_q <= bus.data;
         d_s2_q <= d_s1_q;
         flg_s1_q <= bus.group_inversion_flags;
         flg_s2_q <= flg_s1_q;
         par_s1_q <= bus.data_parity_lines;
         par_s2_q <= par_s1_q;
         {ps_s3_q, ps_s2_q, ps_s1_q} <= {ps_s2_q, ps_s1_q, bus.positive_data_strobes};
         {ns_s3_q, ns_s2_q, ns_s1_q} <= {ns_s2_q, ns_s1_q, bus.negative_data_strobes};
         data_valid_indicator_s_q <= {data_valid_indicator_s_q[0], bus.data_valid_indicator};
         busy_s_q <= {busy_s_q[0], bus.data_bus_in_use};
         out_of_order_a_s_q <= {out_of_order_a_s_q[0], bus.out_of_order_a};
      end
   end

   // ----------------------------------------
   // Out_of_order_a status
   // ----------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         deferred_q <= 1'b0;
      end else begin
         deferred_q <= ~out_of_order_a_s_q[1];
      end
   end

   // ----------------------------------------
   // Word encoder
   // ----------------------------------------
   always_comb begin
      word = line_q[{ph_q[2:1], 6'h00} +: 64];
      for (int g = 0; g < qpdp_pkg::NG; g++) begin
         // Group g uses lines 16g+15..16g, flag g and parity g
         {enc_f[g], enc_d[g*16 +: 16]} = qpdp_pkg::qpdp_dbi_enc(word[g*16 +: 16], prev_q[g*16 +: 16]);
         enc_p[g] = qpdp_pkg::qpdp_par(enc_d[g*16 +: 16]);
      end
   end

   // ----------------------------------------
   // Transmit sequencer
   // ----------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state_q <= qpdp_pkg::ST_IDLE;
         ph_q <= 3'h0;
         line_q <= '0;
         last_q <= 1'b0;
         tx_ready_q <= 1'b0;
         prev_q <= qpdp_pkg::IDLE_DATA;
         bus.cpu_data_o <= qpdp_pkg::IDLE_DATA;
         bus.cpu_flag_o <= qpdp_pkg::IDLE_GRP;
         bus.cpu_par_o <= qpdp_pkg::IDLE_GRP;
         bus.cpu_pstb_o <= qpdp_pkg::IDLE_GRP;
         bus.cpu_nstb_o <= qpdp_pkg::IDLE_GRP;
         bus.cpu_data_valid_indicator_o <= 1'b1;
         bus.cpu_drv_oe_n <= 1'b1;
         bus.cpu_busy_o <= 1'b0;
         bus.cpu_busy_oe_n <= 1'b1;
      end else begin
         tx_ready_q <= 1'b0;
         case (state_q)
            qpdp_pkg::ST_IDLE: begin
               // Claim only while nobody holds the bus
               if (bclk_rise && tx_valid && busy_s_q[1]) begin
                  line_q <= tx_line;
                  last_q <= tx_last;
                  tx_ready_q <= 1'b1;
                  ph_q <= 3'h0;
                  bus.cpu_drv_oe_n <= 1'b0;
                  bus.cpu_busy_oe_n <= 1'b0;
                  state_q <= qpdp_pkg::ST_SEND;
               end
            end
            qpdp_pkg::ST_SEND: begin
               ph_q <= ph_q + 3'h1;
               if (!ph_q[0]) begin
                  // New word, two sys cycles each
                  bus.cpu_data_o <= enc_d;
                  bus.cpu_flag_o <= enc_f;
                  bus.cpu_par_o <= enc_p;
                  prev_q <= enc_d;
                  bus.cpu_pstb_o <= qpdp_pkg::IDLE_GRP;
                  bus.cpu_nstb_o <= qpdp_pkg::IDLE_GRP;
                  bus.cpu_data_valid_indicator_o <= 1'b0;
               end else if (!ph_q[1]) begin
                  // Words 0 and 2 on the positive strobes
                  bus.cpu_pstb_o <= 4'h0;
               end else begin
                  // Words 1 and 3 on the negative strobes
                  bus.cpu_nstb_o <= 4'h0;
               end
               if (ph_q == qpdp_pkg::PH_LAST) begin
                  state_q <= qpdp_pkg::ST_GAP;
               end
            end
            qpdp_pkg::ST_GAP: begin
               bus.cpu_data_valid_indicator_o <= 1'b1;
               bus.cpu_pstb_o <= qpdp_pkg::IDLE_GRP;
               bus.cpu_nstb_o <= qpdp_pkg::IDLE_GRP;
               if (last_q) begin
                  bus.cpu_drv_oe_n <= 1'b1;
                  bus.cpu_busy_oe_n <= 1'b1;
                  bus.cpu_data_o <= qpdp_pkg::IDLE_DATA;
                  bus.cpu_flag_o <= qpdp_pkg::IDLE_GRP;
                  prev_q <= qpdp_pkg::IDLE_DATA;
                  state_q <= qpdp_pkg::ST_IDLE;
               end else if (bclk_rise && tx_valid) begin
                  line_q <= tx_line;
                  last_q <= tx_last;
                  tx_ready_q <= 1'b1;
                  ph_q <= 3'h0;
                  state_q <= qpdp_pkg::ST_SEND;
               end
            end
            default: begin
               state_q <= qpdp_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Receiver
   // ----------------------------------------
   // Own strobes come back through the synchronisers late
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         own_q <= 3'h0;
      end else begin
         own_q <= {own_q[1:0], ~bus.cpu_drv_oe_n};
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         widx_q <= '{default: 2'h0};
         done_q <= 4'h0;
         rx_line_q <= '0;
         rx_valid_q <= 1'b0;
         par_err_q <= 1'b0;
      end else begin
         rx_valid_q <= &done_q;
         par_err_q <= 1'b0;
         if (busy_s_q[1] || (&done_q)) begin
            done_q <= 4'h0;
         end
         for (int g = 0; g < qpdp_pkg::NG; g++) begin
            if (busy_s_q[1]) begin
               widx_q[g] <= 2'h0;
            end
            if (((ps_s3_q[g] & ~ps_s2_q[g]) | (ns_s3_q[g] & ~ns_s2_q[g])) && !data_valid_indicator_s_q[1]
                && !(|own_q) && bus.cpu_drv_oe_n) begin
               rx_line_q[{widx_q[g], 2'(g), 4'h0} +: 16] <=
                  qpdp_pkg::qpdp_dbi_dec(d_s2_q[g*16 +: 16], flg_s2_q[g]);
               if (qpdp_pkg::qpdp_par(d_s2_q[g*16 +: 16]) != par_s2_q[g]) begin
                  par_err_q <= 1'b1;
               end
               widx_q[g] <= widx_q[g] + 2'h1;
               if (widx_q[g] == 2'h3) begin
                  done_q[g] <= 1'b1;
               end
            end
         end
      end
   end

endmodule

/* test/qpdp_chk.sv */
`timescale 1ns/1ps
module qpdp_chk (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [63:0] data,
   input wire logic [3:0] positive_data_strobes,
   input wire logic [3:0] negative_data_strobes,
   input wire logic [3:0] group_inversion_flags,
   input wire logic [3:0] data_parity_lines,
   input wire logic data_valid_indicator,
   input wire logic data_bus_in_use
);
   // ----------------------------------------
   // Wire-level checks
   // ----------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // No group flips more than half its lines
   function automatic bit few(input logic [63:0] a, input logic [63:0] b);
      few = 1'b1;
      for (int g = 0; g < 4; g++) begin
         if ($countones(a[16*g+:16] ^ b[16*g+:16]) > 8) few = 1'b0;
      end
   endfunction
   AST_PARITY: assert property (!data_valid_indicator |-> data_parity_lines ==
      {^data[63:48], ^data[47:32], ^data[31:16], ^data[15:0]}) else $error("parity lines wrong");
   AST_BUSY: assert property (!data_valid_indicator |-> !data_bus_in_use)
      else $error("data valid without busy");
   AST_STROBE: assert property ((positive_data_strobes & negative_data_strobes) != 4'hf |->
      !data_valid_indicator) else $error("strobe without data valid");
   AST_FOUR: assert property ($fell(data_valid_indicator) |->
      !data_valid_indicator [*8] ##1 data_valid_indicator) else $error("chunk length wrong");
   AST_ORDER: assert property ($fell(data_valid_indicator) |-> ##1 positive_data_strobes == 4'h0
      ##2 negative_data_strobes == 4'h0 ##2 positive_data_strobes == 4'h0 ##2 negative_data_strobes == 4'h0)
      else $error("strobe order wrong");
   AST_HOLD: assert property ($fell(positive_data_strobes[0]) || $fell(negative_data_strobes[0]) |->
      $stable(data) && $stable(group_inversion_flags)) else $error("lines moved at strobe");
   AST_IDLE: assert property (data_bus_in_use |-> data == 64'hffff_ffff_ffff_ffff &&
      group_inversion_flags == 4'hf && data_valid_indicator) else $error("lines driven while free");
   AST_DBI: assert property (!data_valid_indicator && !$past(data_valid_indicator) |->
      few(data, $past(data))) else $error("group flipped too many lines");
endmodule

/* test/quad_pumped_data_phase_tb_top.sv */
`timescale 1ns/1ps
module quad_pumped_data_phase_tb_top;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic cv = 1'b0, hv = 1'b0, tl = 1'b0, dq = 1'b0;
   logic [255:0] ln = 256'h0;
   logic cr, hr, cx, hx, ce, he, df;
   logic [255:0] crl, hrl, got;
   int errors = 0, checks = 0, cyc = 0, nrx = 0, perr = 0;
   logic [255:0] rl [5] = '{{4{64'h0000_0000_0000_0000}}, {4{64'hffff_ffff_ffff_ffff}},
      {2{64'h0000_0000_0000_0000, 64'hffff_ffff_ffff_ffff}}, {4{64'h00ff_0f0f_3333_5555}},
      {64'h8000_0000_0000_0001, 64'h7fff_ffff_ffff_fffe, 64'h0123_4567_89ab_cdef, 64'hfedc_ba98_7654_3210}};
   logic [4:0] rlast = 5'h15;
   qpdp_bus_if bus ();
   qpdp_cpu_end u_qpdp_cpu_end (.clk_sys(clk_sys), .rst_n(rst_n), .tx_valid(cv), .tx_line(ln), .tx_last(tl),
      .tx_ready(cr), .rx_valid(cx), .rx_line(crl), .rx_par_err(ce), .deferred(df), .bus(bus));
   qpdp_chip_end u_qpdp_chip_end (.clk_sys(clk_sys), .rst_n(rst_n), .tx_valid(hv), .tx_line(ln), .tx_last(tl),
      .out_of_order_a_req(dq), .tx_ready(hr), .rx_valid(hx), .rx_line(hrl), .rx_par_err(he), .bus(bus));
   qpdp_chk u_qpdp_chk (.clk_sys(clk_sys), .rst_n(rst_n), .data(bus.data),
      .positive_data_strobes(bus.positive_data_strobes), .negative_data_strobes(bus.negative_data_strobes),
      .group_inversion_flags(bus.group_inversion_flags), .data_parity_lines(bus.data_parity_lines),
      .data_valid_indicator(bus.data_valid_indicator), .data_bus_in_use(bus.data_bus_in_use));
   // ----------------------------------------
   // Clocks, capture and watchdog
   // ----------------------------------------
   always #12.5 clk_sys = ~clk_sys;
   initial begin
      bus.bus_clk = 1'b0;
      #37;
      forever #100 bus.bus_clk = ~bus.bus_clk;
   end
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cx) got <= crl;
      if (hx) got <= hrl;
      if (cx | hx) nrx <= nrx + 1;
      if (ce | he) perr <= perr + 1;
      if (cyc == 5000) begin
         errors++;
         give_verdict();
      end
   end
   task automatic cmp(input logic [255:0] a, input logic [255:0] e);
      checks++;
      if (a !== e) begin
         errors++;
         $display("unexpected at %0t: got %h want %h", $time, a, e);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Send one line from cpu (c=1) or chip end, then check what the other end got
   task automatic xfer(input bit c, input logic [255:0] l, input logic lst);
      int n;
      int r;
      n = 0;
      r = nrx;
      ln <= l;
      tl <= lst;
      if (c) cv <= 1'b1;
      else hv <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (!(c ? cr : hr) && n < 100);
      cv <= 1'b0;
      hv <= 1'b0;
      while (nrx == r && n < 200) begin
         @(posedge clk_sys);
         n++;
      end
      cmp(256'(nrx - r), 256'h1);
      cmp(got, l);
   endtask
   initial begin
      repeat (16) @(posedge clk_sys);
      rst_n <= 1'b1;
      for (int i = 0; i < 5; i++) xfer(i < 3, rl[i], rlast[i]);
      cmp(256'({bus.data, bus.data_bus_in_use}), {191'h0, 64'hffff_ffff_ffff_ffff, 1'b1});
      dq <= 1'b1;
      repeat (5) @(posedge clk_sys);
      cmp(256'({bus.out_of_order_a, df}), 256'h1);
      dq <= 1'b0;
      repeat (5) @(posedge clk_sys);
      cmp(256'({bus.out_of_order_a, df}), 256'h2);
      dq <= 1'b1;
      repeat (5) @(posedge clk_sys);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      cmp(256'({df, cr, cx, bus.out_of_order_a, bus.data_bus_in_use}), 256'h3);
      cmp(crl, 256'h0);
      dq <= 1'b0;
      rst_n <= 1'b1;
      xfer(1'b1, rl[4], 1'b1);
      cmp(256'(perr), 256'h0);
      give_verdict();
   end
endmodule
